// ===== verilog/otppv_pkg.sv
package otppv_pkg;

    // Link geometry
    localparam int NIB_W      = 4;
    localparam int ADDR_W     = 10;
    localparam int WORD_W     = 14;
    localparam int OPT_W      = 8;
    localparam int FRAME_W    = 16;
    localparam int PROG_DEPTH = 1024;
    localparam int OPT_DEPTH  = 16;
    localparam int TEST_DEPTH = 16;

    // Nibble positions inside a four-beat phase
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST  = 2'h3;
    localparam int         TEST_ARRAY_SELECT_POS   = 2;
    localparam int         OPTION_ARRAY_SELECT_POS   = 3;
    localparam int         A_HI_LSB   = 8;

    // Code protection flag lives in one option byte
    localparam logic [3:0] LOCK_IDX = 4'hF;
    localparam int         LOCK_BIT = 0;

    // Controller register map (word index on the local port)
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_WDATA  = 4'h2;
    localparam logic [3:0] REG_RDATA  = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;

    // Command register bits
    localparam int CMD_START = 0;
    localparam int CMD_READ  = 1;
    localparam int CMD_SEQ   = 2;
    localparam int CMD_END   = 3;
    localparam int CMD_TEST_ARRAY_SELECT  = 4;
    localparam int CMD_OPTION_ARRAY_SELECT  = 5;

    // Status register bits
    localparam int STS_BUSY = 0;
    localparam int STS_SEL  = 1;

    // Array select, coded as {option_array_select, test_array_select}
    typedef enum logic [1:0] {
        SEL_PROG = 2'b00,
        SEL_TEST = 2'b01,
        SEL_OPT  = 2'b10,
        SEL_NONE = 2'b11
    } otppv_sel_t;

    // Pick nibble number idx out of a 16-bit frame
    function automatic logic [3:0] otppv_nib(input logic [15:0] frame, input logic [1:0] idx);
        otppv_nib = frame[{idx, 2'b00} +: 4];
    endfunction

endpackage

// ===== verilog/otppv_if.sv
`timescale 1ns/100ps
// Wires between the programmer and the memory port
interface otppv_if;
    // Serial clock, select and direction, all from the programmer
    logic       sclk;
    logic       cs_n;
    logic       rw;
    // Each party's drive onto the shared nibble bus
    logic [3:0] p_nib;
    logic       p_oe_n;
    logic [3:0] d_nib;
    logic       d_oe_n;
    // Resolved bus; an undriven bus floats high through the pull-ups
    logic [3:0] nibble_bus;

    assign nibble_bus = !p_oe_n ? p_nib : (!d_oe_n ? d_nib : 4'hF);

    modport dev (
        input  sclk,
        input  cs_n,
        input  rw,
        input  nibble_bus,
        output d_nib,
        output d_oe_n
    );

    modport prog (
        output sclk,
        output cs_n,
        output rw,
        output p_nib,
        output p_oe_n,
        input  nibble_bus
    );
endinterface

// ===== verilog/otppv_sync.sv
`timescale 1ns/100ps
// Two-stage level synchroniser; only stage two may be read
module otppv_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input  wire logic             clk_i,
    // Asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    // No reset: the chain flushes itself in two edges
    always_ff @(posedge clk_i) begin
        meta_reg <= d_i;
        q_o      <= meta_reg;
    end
endmodule

// ===== verilog/otppv_dev.sv
`timescale 1ns/100ps
// Functional notes
// - Nibbles move on serial clock falling edges
// - Address beats: bits 0-3, 4-7, 8-9
// - Fourth address beat: bit2 test, bit3 option
// - Selects pick test, option or program array
// - Word moves as four nibbles, low first
// - Verify returns zeros in bits 14-15
// - Direction pin picks program or verify
// - Word address increments after each verify
// - Random access needs chip select raised
// - Port acts only while chip select low
// - Lock set makes code reads all ones
// - Program 1024x14 and option 16x8 arrays
module otppv_dev
    import otppv_pkg::*;
#(
    parameter logic [15:0] TEST_SEED = 16'h5A3C  // Arbitrary test-array pattern
) (
    // Link to the programmer
    otppv_if.dev                       link,
    // Reset
    input  wire logic                  rst_n_i,
    // Status seen by the host chip
    output logic                       lock_o,
    output otppv_pkg::otppv_sel_t      sel_o,
    output logic [otppv_pkg::ADDR_W-1:0] word_addr_o
);
    import otppv_pkg::*;

    typedef enum logic {
        DS_ADDR = 1'b0,
        DS_DATA = 1'b1
    } otppv_dstate_t;

    // Storage arrays
    logic [WORD_W-1:0] prog_mem [PROG_DEPTH];
    logic [OPT_W-1:0]  opt_mem  [OPT_DEPTH];

    // Sequencer state
    logic               rst_meta_reg;
    logic               rst_sync_reg;
    otppv_dstate_t      state_reg,   state_next;
    logic [1:0]         beat_reg,    beat_next;
    logic [ADDR_W-1:0]  addr_reg,    addr_next;
    otppv_sel_t         sel_reg,     sel_next;
    logic [11:0]        wbuf_reg,    wbuf_next;
    logic [NIB_W-1:0]   out_nib_reg, out_nib_next;
    logic               out_oe_n_reg, out_oe_n_next;
    logic               lock_reg;

    // Decode of the beat just clocked
    wire                selected   = rst_sync_reg && !link.cs_n;
    wire                is_read    = link.rw;
    wire [NIB_W-1:0]    bus        = link.nibble_bus;
    wire otppv_sel_t    sel_bus    = otppv_sel_t'({bus[OPTION_ARRAY_SELECT_POS], bus[TEST_ARRAY_SELECT_POS]});
    wire                last_beat  = (beat_reg == BEAT_LAST);
    wire [1:0]          beat_inc   = beat_reg + 2'h1;
    wire [ADDR_W-1:0]   addr_inc   = addr_reg + 10'h001;
    wire [WORD_W-1:0]   wr_word    = {bus[1:0], wbuf_reg};
    wire                do_write   = selected && state_reg == DS_DATA && !is_read && last_beat;
    wire                lock_now   = opt_mem[LOCK_IDX][LOCK_BIT];

    // Frame that a verify returns for a given address and array
    function automatic logic [15:0] read_frame(input logic [ADDR_W-1:0] a,
                                               input otppv_sel_t s);
        logic [15:0] f;
        f = 16'h0000;
        case (s)
            SEL_PROG: f = lock_now ? {2'b00, {WORD_W{1'b1}}}
                                   : {2'b00, prog_mem[a]};
            SEL_TEST: f = {2'b00, TEST_SEED[13:0] ^ {10'h000, a[3:0]}};
            SEL_OPT:  f = {8'h00, opt_mem[a[3:0]]};
            default:  f = 16'h0000;
        endcase
        read_frame = f;
    endfunction

    wire [15:0] cur_frame = read_frame(addr_reg, sel_reg);
    wire [15:0] nxt_frame = read_frame(addr_inc, sel_reg);
    wire [15:0] new_frame = read_frame(addr_reg, sel_bus);

    // Sequencer next state; everything rests while deselected
    always_comb begin
        state_next    = state_reg;
        beat_next     = beat_reg;
        addr_next     = addr_reg;
        sel_next      = sel_reg;
        wbuf_next     = wbuf_reg;
        out_nib_next  = out_nib_reg;
        out_oe_n_next = 1'b1;
        if (!selected) begin
            state_next = DS_ADDR;
            beat_next  = BEAT_FIRST;
            wbuf_next  = 12'h000;
        end else begin
            case (state_reg)
                DS_ADDR: begin
                    beat_next = beat_inc;
                    case (beat_reg)
                        2'h0: addr_next[3:0] = bus;
                        2'h1: addr_next[7:4] = bus;
                        2'h2: addr_next[ADDR_W-1:A_HI_LSB] = bus[1:0];
                        default: begin
                            // Low two bits of this beat carry nothing
                            sel_next   = sel_bus;
                            state_next = DS_DATA;
                            beat_next  = BEAT_FIRST;
                            if (is_read) begin
                                out_nib_next  = otppv_nib(new_frame, BEAT_FIRST);
                                out_oe_n_next = 1'b0;
                            end
                        end
                    endcase
                end
                DS_DATA: begin
                    beat_next = beat_inc;
                    if (is_read) begin
                        out_oe_n_next = 1'b0;
                        if (last_beat) begin
                            addr_next    = addr_inc;
                            out_nib_next = otppv_nib(nxt_frame, BEAT_FIRST);
                        end else begin
                            out_nib_next = otppv_nib(cur_frame, beat_inc);
                        end
                    end else begin
                        // Collect the low three nibbles; the fourth commits
                        case (beat_reg)
                            2'h0:    wbuf_next[3:0]  = bus;
                            2'h1:    wbuf_next[7:4]  = bus;
                            2'h2:    wbuf_next[11:8] = bus;
                            default: wbuf_next       = 12'h000;
                        endcase
                    end
                end
                default: begin
                    state_next = DS_ADDR;
                    beat_next  = BEAT_FIRST;
                end
            endcase
        end
    end

    // Reset is a pin from outside this clock, so it is synchronised first
    always_ff @(negedge link.sclk) begin
        rst_meta_reg <= rst_n_i;
        rst_sync_reg <= rst_meta_reg;
    end

    // Sequencer registers advance on the falling edge only
    always_ff @(negedge link.sclk) begin
        if (!rst_sync_reg) begin
            state_reg    <= DS_ADDR;
            beat_reg     <= BEAT_FIRST;
            addr_reg     <= 10'h000;
            sel_reg      <= SEL_PROG;
            wbuf_reg     <= 12'h000;
            out_nib_reg  <= 4'h0;
            out_oe_n_reg <= 1'b1;
            lock_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            beat_reg     <= beat_next;
            addr_reg     <= addr_next;
            sel_reg      <= sel_next;
            wbuf_reg     <= wbuf_next;
            out_nib_reg  <= out_nib_next;
            out_oe_n_reg <= out_oe_n_next;
            lock_reg     <= lock_now;
        end
    end

    // Blank parts read as zero; the arrays are not cleared by reset
    initial begin
        for (int i = 0; i < PROG_DEPTH; i++) begin
            prog_mem[i] = 14'h0000;
        end
        for (int j = 0; j < OPT_DEPTH; j++) begin
            opt_mem[j] = 8'h00;
        end
    end

    // One-time cells can only be set, never cleared again
    always_ff @(negedge link.sclk) begin
        if (do_write && sel_reg == SEL_PROG) begin
            prog_mem[addr_reg] <= prog_mem[addr_reg] | wr_word;
        end
        if (do_write && sel_reg == SEL_OPT) begin
            opt_mem[addr_reg[3:0]] <= opt_mem[addr_reg[3:0]] | wr_word[OPT_W-1:0];
        end
    end

    // Port drive and status
    assign link.d_nib   = out_nib_reg;
    assign link.d_oe_n  = out_oe_n_reg;
    assign lock_o       = lock_reg;
    assign sel_o        = sel_reg;
    assign word_addr_o  = addr_reg;
endmodule

// ===== verilog/otppv_prog.sv
`timescale 1ns/100ps
// Programmer end: runs the serial link from a local register port
module otppv_prog
    import otppv_pkg::*;
#(
    parameter int SCLK_HALF = 4,  // System clocks per half serial period
    parameter int CS_GAP    = 2   // Falling edges in the gap; chip select is raised after the first of them unless CS_GAP is 1
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Local register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    // Link to the device
    otppv_if.prog            link
);
    import otppv_pkg::*;

    initial begin
        if (SCLK_HALF < 2 || SCLK_HALF > 255 || CS_GAP < 1 || CS_GAP > 15) begin
            $error("otppv_prog: unsupported SCLK_HALF or CS_GAP");
        end
    end

    typedef enum logic [2:0] {
        PS_IDLE = 3'b000,
        PS_GAP  = 3'b001,
        PS_LEAD = 3'b010,
        PS_ADDR = 3'b011,
        PS_DATA = 3'b100
    } otppv_pstate_t;

    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
    localparam logic [3:0] GAP_LAST  = 4'(CS_GAP - 1);

    otppv_pstate_t      state_reg;
    logic [7:0]         half_reg;
    logic [3:0]         gap_reg;
    logic [1:0]         beat_reg;
    logic [ADDR_W-1:0]  addr_reg;
    logic [WORD_W-1:0]  wdata_reg;
    logic [15:0]        rframe_reg;
    logic               read_reg;
    logic               test_array_select_reg;
    logic               option_array_select_reg;
    logic               sclk_reg;
    logic               cs_n_reg;
    logic [3:0]         nib_reg;
    logic               oe_n_reg;
    logic [NIB_W-1:0]   bus_sync;
    logic               fall_d_reg;

    // Frames sent on the link
    wire [15:0] addr_frame = {option_array_select_reg, test_array_select_reg, 2'b00, 2'b00, addr_reg};
    wire [15:0] data_frame = {2'b00, wdata_reg};
    wire        idle       = (state_reg == PS_IDLE);
    wire        tick       = !idle && (half_reg == HALF_LAST);
    wire        fall       = tick && sclk_reg;
    wire        cmd_wr     = wr_i && addr_i == REG_CMD && idle;
    wire        start      = cmd_wr && wdata_i[CMD_START];
    wire        seq_ok     = start && wdata_i[CMD_SEQ] && !cs_n_reg;
    wire [1:0]  beat_inc   = beat_reg + 2'h1;

    // Read data return from the device, crossing from the pins
    otppv_sync #(.WIDTH(NIB_W)) u_bus_sync (
        .clk_i (sys_clk_i),
        .d_i   (link.nibble_bus),
        .q_o   (bus_sync)
    );

    // Serial clock divider; clock parks high between operations
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || idle || tick) begin
            half_reg <= 8'h00;
        end else begin
            half_reg <= half_reg + 8'h01;
        end
        // Link outputs move one cycle after the fall, so the port never races them
        fall_d_reg <= rst_n_i && fall;
        if (!rst_n_i || idle) begin
            sclk_reg <= 1'b1;
        end else if (tick) begin
            sclk_reg <= !sclk_reg;
        end
    end

    // Operation sequencer; link outputs change one cycle after a falling edge, except in PS_LEAD and on an end command
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= PS_IDLE;
            gap_reg   <= 4'h0;
            beat_reg  <= BEAT_FIRST;
            cs_n_reg  <= 1'b1;
            nib_reg   <= 4'h0;
            oe_n_reg  <= 1'b1;
        end else begin
            case (state_reg)
                PS_IDLE: begin
                    if (cmd_wr && wdata_i[CMD_END]) begin
                        cs_n_reg <= 1'b1;  // Ends a sequential run
                    end
                    if (start) begin
                        state_reg <= seq_ok ? PS_LEAD : PS_GAP;
                        gap_reg   <= 4'h0;
                    end
                end
                PS_GAP: if (fall_d_reg) begin
                    cs_n_reg <= 1'b1;
                    gap_reg  <= gap_reg + 4'h1;
                    if (gap_reg == GAP_LAST) begin
                        cs_n_reg  <= 1'b0;
                        nib_reg   <= otppv_nib(addr_frame, BEAT_FIRST);
                        oe_n_reg  <= 1'b0;
                        beat_reg  <= BEAT_FIRST;
                        state_reg <= PS_ADDR;
                    end
                end
                PS_ADDR: if (fall_d_reg) begin
                    beat_reg <= beat_inc;
                    nib_reg  <= otppv_nib(addr_frame, beat_inc);
                    if (beat_reg == BEAT_LAST) begin
                        nib_reg   <= otppv_nib(data_frame, BEAT_FIRST);
                        oe_n_reg  <= read_reg;
                        state_reg <= PS_DATA;
                    end
                end
                // No extra fall here: the port already waits at data beat 0
                PS_LEAD: begin
                    beat_reg  <= BEAT_FIRST;
                    nib_reg   <= otppv_nib(data_frame, BEAT_FIRST);
                    oe_n_reg  <= read_reg;
                    state_reg <= PS_DATA;
                end
                PS_DATA: if (fall_d_reg) begin
                    beat_reg <= beat_inc;
                    nib_reg  <= otppv_nib(data_frame, beat_inc);
                    if (beat_reg == BEAT_LAST) begin
                        oe_n_reg  <= 1'b1;
                        state_reg <= PS_IDLE;
                    end
                end
                default: state_reg <= PS_IDLE;
            endcase
        end
    end

    // Command fields and captured read frame
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            addr_reg   <= 10'h000;
            wdata_reg  <= 14'h0000;
            read_reg   <= 1'b0;
            test_array_select_reg   <= 1'b0;
            option_array_select_reg   <= 1'b0;
            rframe_reg <= 16'h0000;
        end else begin
            if (wr_i && addr_i == REG_ADDR && idle) begin
                addr_reg <= wdata_i[ADDR_W-1:0];
            end
            if (wr_i && addr_i == REG_WDATA && idle) begin
                wdata_reg <= wdata_i[WORD_W-1:0];
            end
            if (start) begin
                read_reg <= wdata_i[CMD_READ];
                test_array_select_reg <= wdata_i[CMD_TEST_ARRAY_SELECT];
                option_array_select_reg <= wdata_i[CMD_OPTION_ARRAY_SELECT];
            end
            if (state_reg == PS_DATA && fall && read_reg) begin
                rframe_reg[{beat_reg, 2'b00} +: 4] <= bus_sync;
            end
        end
    end

    // Register read-back, one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !rd_i) begin
            rdata_o <= 16'h0000;
        end else begin
            case (addr_i)
                REG_ADDR:   rdata_o <= {6'h00, addr_reg};
                REG_WDATA:  rdata_o <= {2'b00, wdata_reg};
                REG_RDATA:  rdata_o <= rframe_reg;
                REG_STATUS: rdata_o <= {14'h0000, !cs_n_reg, !idle};
                default:    rdata_o <= 16'h0000;
            endcase
        end
    end

    assign link.sclk   = sclk_reg;
    assign link.cs_n   = cs_n_reg;
    assign link.rw     = read_reg;
    assign link.p_nib  = nib_reg;
    assign link.p_oe_n = oe_n_reg;
endmodule

// ===== test/otppv_asserts.sv
`timescale 1ns/100ps
// Watches both ends of the serial link
module otppv_asserts (
    // System domain
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    // Link domain reset of the memory port
    input wire logic       dev_rst_n_i,
    // Link signals
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       rw,
    input wire logic [3:0] p_nib,
    input wire logic       p_oe_n,
    input wire logic [3:0] d_nib,
    input wire logic       d_oe_n
);
    // High phase at the default divider lasts four system clocks
    sequence s_high4;
        sclk [*4];
    endsequence
    // Programmer holds bus and select across the sampling edge
    sequence s_held;
        $stable(p_nib) && $stable(p_oe_n) && $stable(cs_n);
    endsequence

    // System-domain properties
    property p_sclk_high;
        @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(sclk) |-> s_high4;
    endproperty
    property p_hold_fall;
        @(posedge sys_clk_i) disable iff (!rst_n_i) $fell(sclk) |-> s_held;
    endproperty
    property p_prog_move;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            ($changed(p_nib) || $changed(p_oe_n)) |-> $past(sclk, 2) && !$past(sclk);
    endproperty
    property p_dev_move;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            ($changed(d_nib) || $changed(d_oe_n)) |-> $fell(sclk);
    endproperty
    property p_drive_sel;
        @(posedge sys_clk_i) disable iff (!rst_n_i) $fell(p_oe_n) |-> !cs_n;
    endproperty
    property p_rel_desel;
        @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(cs_n) |-> p_oe_n;
    endproperty
    // Link-domain properties; the port acts on falling edges only
    property p_desel;
        @(negedge sclk) disable iff (!dev_rst_n_i) cs_n |=> d_oe_n;
    endproperty
    property p_dir;
        @(negedge sclk) disable iff (!dev_rst_n_i) !rw |=> d_oe_n;
    endproperty

    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high phase cut short");
    a_hold_fall: assert property (p_hold_fall)
        else $error("programmer moved at a falling edge");
    a_prog_move: assert property (p_prog_move)
        else $error("programmer drive moved away from a fall");
    a_dev_move: assert property (p_dev_move)
        else $error("port drive moved away from a fall");
    a_drive_sel: assert property (p_drive_sel)
        else $error("programmer drives while deselected");
    a_rel_desel: assert property (p_rel_desel)
        else $error("select raised with bus still driven");
    a_desel: assert property (p_desel)
        else $error("port drives after deselect");
    a_dir: assert property (p_dir)
        else $error("port drives during programming");
endmodule

// ===== test/otp_program_verify_port_tb.sv
`timescale 1ns/100ps
// Programmer and memory port back to back, run through the register port
module otp_program_verify_port_tb;
    import otppv_pkg::*;
    localparam logic [15:0] SEED = 16'h1D2E;  // Arbitrary test-array pattern
    localparam logic [15:0] RD = 16'h0001 << CMD_READ;
    localparam logic [15:0] SQ = 16'h0001 << CMD_SEQ;
    localparam logic [15:0] EN = 16'h0001 << CMD_END;
    localparam logic [15:0] TS = 16'h0001 << CMD_TEST_ARRAY_SELECT;
    localparam logic [15:0] OS = 16'h0001 << CMD_OPTION_ARRAY_SELECT;

    // Stimulus, observation and score
    logic              sys_clk_i;
    logic              rst_n_i;
    logic              dev_rst_n_i;
    logic [3:0]        addr_i;
    logic [15:0]       wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [15:0]       rdata_o;
    logic              lock_o;
    otppv_sel_t        sel_o;
    logic [ADDR_W-1:0] word_addr_o;
    logic [15:0]       v;
    int                bad_count;
    int                n_tests;

    // Both ends and the checker on one link
    otppv_if link ();
    otppv_prog otppv_prog_i (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .rd_i      (rd_i),
        .rdata_o   (rdata_o),
        .link      (link.prog)
    );
    otppv_dev #(.TEST_SEED(SEED)) otppv_dev_i (
        .link        (link.dev),
        .rst_n_i     (dev_rst_n_i),
        .lock_o      (lock_o),
        .sel_o       (sel_o),
        .word_addr_o (word_addr_o)
    );
    otppv_asserts otppv_asserts_i (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .dev_rst_n_i (dev_rst_n_i),
        .sclk        (link.sclk),
        .cs_n        (link.cs_n),
        .rw          (link.rw),
        .p_nib       (link.p_nib),
        .p_oe_n      (link.p_oe_n),
        .d_nib       (link.d_nib),
        .d_oe_n      (link.d_oe_n)
    );

    // System clock, 4 ns
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // Four-state compare so an unknown never matches
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One-cycle strobes; read data stand only in the cycle after
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    // One link operation; polling is bounded so a hung link ends the run
    task automatic run(input logic [9:0] a, input logic [15:0] d, input logic [15:0] c);
        logic [15:0] s;
        wr(REG_ADDR, {6'h00, a});
        wr(REG_WDATA, d);
        wr(REG_CMD, c | 16'h0001);
        for (int i = 0; i < 200; i++) begin
            rd(REG_STATUS, s);
            if (s[STS_BUSY] === 1'b0) return;
        end
        bad_count++;
        conclude();
    endtask

    // Test array ignores the earlier write and reads its fixed pattern
    task automatic t_test();
        run(10'h005, 16'h0000, RD | TS);
        rd(REG_RDATA, v);
        chk(v, {2'b00, SEED[13:0] ^ 14'h0005});
        chk(16'(sel_o), 16'(SEL_TEST));
    endtask
    // Top of the array, out-of-order verify, then a follow-on verify
    task automatic t_prog();
        run(10'h3FE, 16'hD234, 16'h0000);
        run(10'h3FF, 16'h0ABC, 16'h0000);
        run(10'h3FE, 16'h0000, RD);
        rd(REG_RDATA, v);
        chk(v, 16'h1234);
        chk({6'h00, word_addr_o}, 16'h03FF);
        run(10'h000, 16'h0000, RD | SQ);
        rd(REG_RDATA, v);
        chk(v, 16'h0ABC);
        chk(16'(sel_o), 16'(SEL_PROG));
        wr(REG_CMD, EN);
        rd(REG_STATUS, v);
        chk({15'h0000, v[STS_SEL]}, 16'h0000);
    endtask
    // Option bytes are a separate array from program words
    task automatic t_opt();
        run(10'h003, 16'h005A, OS);
        run(10'h003, 16'h0000, RD | OS);
        rd(REG_RDATA, v);
        chk(v, 16'h005A);
        chk(16'(sel_o), 16'(SEL_OPT));
        run(10'h003, 16'h0000, RD);
        rd(REG_RDATA, v);
        chk(v, 16'h0000);
        chk({15'h0000, lock_o}, 16'h0000);
    endtask
    // Setting the lock hides code; lock flag seen after the next frame
    task automatic t_lock();
        run(10'h00F, 16'h0001, OS);
        run(10'h3FE, 16'h0000, RD);
        rd(REG_RDATA, v);
        chk(v, 16'h3FFF);
        chk({15'h0000, lock_o}, 16'h0001);
    endtask
    // Unmapped and write-only places read zero
    task automatic t_regs();
        rd(4'hA, v);
        chk(v, 16'h0000);
        rd(REG_CMD, v);
        chk(v, 16'h0000);
    endtask

    // Main sequence; the port resets only on serial edges, so a frame runs under reset
    initial begin
        rst_n_i     = 1'b0;
        dev_rst_n_i = 1'b0;
        addr_i      = 4'h0;
        wdata_i     = 16'h0000;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        bad_count   = 0;
        n_tests     = 0;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        run(10'h005, 16'h3FFF, TS);
        dev_rst_n_i <= 1'b1;
        run(10'h005, 16'h3FFF, TS);
        t_test();
        t_prog();
        t_opt();
        t_lock();
        t_regs();
        conclude();
    end
endmodule
